//--- tss_scan_sequencer.sv
// scan sequencer and measurement controller for sixteen thermocouple inputs
`timescale 1ns/1ps
`include "tss_regs.svh"
module tss_scan_sequencer import tss_pkg::*; #(
    parameter int unsigned SLOT_CYCLES = `TSS_SLOT_CYC,
    parameter int unsigned WIRE_CYCLES = `TSS_WIRE_CYC,
    parameter int unsigned WDOG_CYCLES = `TSS_WDOG_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // host configuration
    input wire logic CFG_LOAD,
    input wire tss_cfg_s CFG_IN,
    input wire logic [2:0] FILTER_SEL,
    // converter
    output tss_adc_req_s ADC_REQ,
    input wire logic ADC_DONE,
    input wire logic [15:0] ADC_DATA_A,
    input wire logic [15:0] ADC_DATA_B,
    // wire test
    output logic WIRE_TEST_ACT,
    output logic [3:0] WIRE_TEST_CHAN,
    input wire logic WIRE_OPEN,
    // module monitoring
    input wire logic TERM_PRESENT,
    // host side results
    output logic [15:0][15:0] VALUES,
    output logic [15:0] CH_OVER,
    output logic [15:0] CH_UNDER,
    output logic [15:0] CH_FAULT,
    output tss_status_s MOD_STATUS,
    output logic CYCLE_DONE
);
    if (SLOT_CYCLES < 2 || WIRE_CYCLES < 2 || WDOG_CYCLES <= SLOT_CYCLES) begin : g_chk
        $error("tss_scan_sequencer: slot, wire or watchdog count too small");
    end

    // lowest set bit of m at or above from, or none
    function automatic logic [4:0] tss_next(input logic [15:0] m, input logic [4:0] from);
        logic [4:0] r;
        r = `TSS_IDX_NONE;
        for (int i = `TSS_NCH - 1; i >= 0; i--) begin
            if (5'(i) >= from && m[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] wire_mask(input tss_cfg_s c);
        return c.fast ? c.in_use : `TSS_ALL_CH; // [RULE_02] [RULE_03]
    endfunction

    // a pair is visited if either member is in use; normal scan visits all
    function automatic logic [15:0] pair_mask(input tss_cfg_s c);
        return {`TSS_NO_PAIR, c.fast ? (c.in_use[7:0] | c.in_use[15:8]) : `TSS_ALL_PAIR}; // [RULE_05]
    endfunction

    // next step after p in the fixed order self-cal, cold junction, wire, pairs
    function automatic tss_phase_e tss_after(input tss_phase_e p, input tss_cfg_s c);
        logic [2:0] rank;
        unique case (p)
            TSS_ST_START: rank = 3'h0;
            TSS_ST_SELFCAL: rank = 3'h1;
            TSS_ST_CJ: rank = 3'h2;
            TSS_ST_WIRE: rank = 3'h3;
            TSS_ST_PAIR: rank = 3'h4;
            TSS_ST_DONE: rank = 3'h5;
        endcase
        if (rank < 3'h1 && c.self_calibration_mode) begin
            return TSS_ST_SELFCAL; // [RULE_08] [RULE_18]
        end else if (rank < 3'h2 && c.cj_en) begin
            return TSS_ST_CJ; // [RULE_07] [RULE_18]
        end else if (rank < 3'h3 && c.wire_en && wire_mask(c) != '0) begin
            return TSS_ST_WIRE; // [RULE_06] [RULE_18]
        end else if (rank < 3'h4 && pair_mask(c) != '0) begin
            return TSS_ST_PAIR; // [RULE_18]
        end
        return TSS_ST_DONE;
    endfunction

    tss_state_s s_ff;
    tss_state_s nxt_s;
    logic [1:0][15:0] p_filt;
    logic [1:0][15:0] p_scaled;
    logic [1:0] p_over;
    logic [1:0] p_under;

    // both members of the current pair run through identical processing
    for (genvar sd = 0; sd < 2; sd++) begin : g_proc
        localparam logic [3:0] CH_BASE = 4'(sd * 8);
        logic [3:0] ch;
        assign ch = CH_BASE | {1'b0, s_ff.idx[2:0]}; // [RULE_04]
        tss_chan_proc u_proc (
            .raw(sd == 0 ? s_ff.da : s_ff.db),
            .self_off(sd == 0 ? s_ff.off_a : s_ff.off_b),
            .align(s_ff.act.align[ch]),
            .cj(s_ff.cj),
            .cj_add(s_ff.act.range[ch] != `TSS_RANGE_MV), // [RULE_01]
            .prev(s_ff.filt[ch]),
            .fsel(FILTER_SEL),
            .bypass(s_ff.act.fast),
            .gain(s_ff.act.gain),
            .ofs(s_ff.act.ofs),
            .lo(s_ff.act.lo),
            .hi(s_ff.act.hi),
            .filt(p_filt[sd]),
            .scaled(p_scaled[sd]),
            .over(p_over[sd]),
            .under(p_under[sd])
        );
    end

    always_comb begin
        tss_phase_e nph;
        logic [4:0] ni;
        logic enter;
        logic slot_end;
        logic [3:0] ch;
        tss_cfg_s cc;
        nph = s_ff.ph;
        ni = `TSS_IDX_ZERO;
        enter = 1'b0;
        ch = '0;
        cc = (s_ff.ph == TSS_ST_START) ? s_ff.cfg : s_ff.act;
        nxt_s = s_ff;
        nxt_s.adc_go = 1'b0;
        nxt_s.done = 1'b0;
        slot_end = (s_ff.tmr == `TSS_TMR_ZERO);
        if (s_ff.ph != TSS_ST_START && s_ff.ph != TSS_ST_DONE && !slot_end) begin
            nxt_s.tmr = s_ff.tmr - 32'h0000_0001;
        end
        // watchdog: a scan that never completes flags the module
        nxt_s.wdog = s_ff.wdog + 32'h0000_0001;
        nxt_s.stat.wdog_err = s_ff.wdog >= 32'(WDOG_CYCLES); // [RULE_13]
        nxt_s.stat.term_missing = !TERM_PRESENT; // [RULE_13]
        if (CFG_LOAD) begin
            nxt_s.cfg = CFG_IN; // [RULE_14]
        end
        // one result per slot; late or missing results count as chain errors
        if (ADC_DONE && !s_ff.got && (s_ff.ph == TSS_ST_SELFCAL || s_ff.ph == TSS_ST_CJ
            || s_ff.ph == TSS_ST_PAIR)) begin
            nxt_s.got = 1'b1;
            nxt_s.da = ADC_DATA_A; // [RULE_10]
            nxt_s.db = ADC_DATA_B; // [RULE_10]
        end
        unique case (s_ff.ph)
            TSS_ST_START: begin
                // configuration is frozen for the whole scan so outputs stay coherent
                nxt_s.act = s_ff.cfg;
                nxt_s.wflt = '0;
                nxt_s.w_over = '0;
                nxt_s.w_under = '0;
                nxt_s.conv_w = 1'b0;
                nph = tss_after(TSS_ST_START, s_ff.cfg);
                enter = 1'b1;
            end
            TSS_ST_SELFCAL, TSS_ST_CJ: begin
                if (slot_end) begin
                    if (!s_ff.got) begin
                        nxt_s.conv_w = 1'b1; // [RULE_13]
                    end else if (s_ff.ph == TSS_ST_SELFCAL) begin
                        nxt_s.off_a = s_ff.da; // [RULE_08]
                        nxt_s.off_b = s_ff.db;
                    end else begin
                        nxt_s.cj = s_ff.da; // [RULE_07]
                    end
                    nph = tss_after(s_ff.ph, s_ff.act);
                    enter = 1'b1;
                end
            end
            TSS_ST_WIRE: begin
                if (slot_end) begin
                    nxt_s.wflt[s_ff.idx[3:0]] = WIRE_OPEN; // [RULE_06]
                    ni = tss_next(wire_mask(s_ff.act), s_ff.idx + `TSS_IDX_STEP);
                    nph = (ni == `TSS_IDX_NONE) ? tss_after(s_ff.ph, s_ff.act) : s_ff.ph;
                    enter = 1'b1;
                end
            end
            TSS_ST_PAIR: begin
                if (slot_end) begin
                    for (int sd = 0; sd < 2; sd++) begin
                        ch = {sd[0], s_ff.idx[2:0]}; // [RULE_04]
                        if (!s_ff.got) begin
                            nxt_s.conv_w = 1'b1; // [RULE_13]
                        end else if (s_ff.act.in_use[ch]) begin
                            nxt_s.filt[ch] = p_filt[sd]; // [RULE_12]
                            nxt_s.work[ch] = p_scaled[sd];
                            nxt_s.w_over[ch] = p_over[sd];
                            nxt_s.w_under[ch] = p_under[sd];
                        end
                    end
                    ni = tss_next(pair_mask(s_ff.act), s_ff.idx + `TSS_IDX_STEP);
                    nph = (ni == `TSS_IDX_NONE) ? tss_after(s_ff.ph, s_ff.act) : s_ff.ph;
                    enter = 1'b1;
                end
            end
            TSS_ST_DONE: begin
                // values, channel flags and the conversion and range errors change on this single edge
                nxt_s.vals = s_ff.work; // [RULE_09] [RULE_18]
                // published like the values, so a host sampling at any time still sees it
                nxt_s.stat.cfg_err = 1'b0;
                for (int c = 0; c < `TSS_NCH; c++) begin
                    nxt_s.over[c] = s_ff.act.mon_en & s_ff.w_over[c]; // [RULE_17]
                    nxt_s.under[c] = s_ff.act.mon_en & s_ff.w_under[c]; // [RULE_17]
                    nxt_s.fault[c] = s_ff.act.mon_en & s_ff.act.in_use[c]
                        & (s_ff.w_over[c] | s_ff.w_under[c] | s_ff.wflt[c] | s_ff.conv_w); // [RULE_17]
                    if (s_ff.act.range[c] > `TSS_RANGE_MV) begin
                        nxt_s.stat.cfg_err = 1'b1; // [RULE_01]
                    end
                end
                nxt_s.stat.conv_err = s_ff.conv_w; // [RULE_13]
                nxt_s.done = 1'b1; // [RULE_18]
                nxt_s.wdog = '0;
                nph = TSS_ST_START;
            end
            default: begin
                nph = TSS_ST_START;
            end
        endcase
        nxt_s.ph = nph;
        if (enter) begin
            nxt_s.got = 1'b0;
            if (nph == TSS_ST_WIRE && nph != s_ff.ph) begin
                ni = tss_next(wire_mask(cc), `TSS_IDX_ZERO);
            end else if (nph == TSS_ST_PAIR && nph != s_ff.ph) begin
                ni = tss_next(pair_mask(cc), `TSS_IDX_ZERO);
            end
            nxt_s.idx = ni;
            nxt_s.tmr = (nph == TSS_ST_WIRE) ? 32'(WIRE_CYCLES - 1) : 32'(SLOT_CYCLES - 1); // [RULE_05] [RULE_06]
            nxt_s.adc_go = (nph == TSS_ST_SELFCAL || nph == TSS_ST_CJ || nph == TSS_ST_PAIR);
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_ff <= '0;
            s_ff.ph <= TSS_ST_START;
            s_ff.cfg.gain <= `TSS_GAIN_ONE;
            s_ff.cfg.lo <= `TSS_LIM_LO;
            s_ff.cfg.hi <= `TSS_LIM_HI;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // converter and mux control
    always_comb begin
        ADC_REQ.start = s_ff.adc_go;
        ADC_REQ.pair = s_ff.idx[2:0]; // [RULE_04]
        unique case (s_ff.ph)
            TSS_ST_SELFCAL: ADC_REQ.mux = TSS_MUX_REF; // [RULE_11]
            TSS_ST_CJ: ADC_REQ.mux = TSS_MUX_CJ; // [RULE_11]
            default: ADC_REQ.mux = TSS_MUX_CHAN;
        endcase
    end

    assign WIRE_TEST_ACT = (s_ff.ph == TSS_ST_WIRE);
    assign WIRE_TEST_CHAN = s_ff.idx[3:0];
    // the host samples these whenever it likes; all but the terminal and watchdog flags only move at scan end
    assign VALUES = s_ff.vals; // [RULE_09] [RULE_14]
    assign CH_OVER = s_ff.over;
    assign CH_UNDER = s_ff.under;
    assign CH_FAULT = s_ff.fault;
    assign MOD_STATUS = s_ff.stat; // [RULE_14]
    assign CYCLE_DONE = s_ff.done;
endmodule

//--- tss_regs.svh
// constants and behaviour summary of the thermocouple scan sequencer
// Behaviour
// [RULE_01] sixteen inputs, each set to one of ten thermocouple types or +/-80 mV
// [RULE_02] normal scan has fixed duration whatever channels are in use
// [RULE_03] fast scan visits only in-use channels, so duration follows their count
// [RULE_04] channels k and k+8 are converted together as one pair
// [RULE_05] in fast scan a pair with any in-use member costs one 70 ms slot
// [RULE_06] with wire test enabled, each tested channel adds an 8 ms step
// [RULE_07] with cold-junction enabled, each scan adds a 70 ms cold-junction conversion
// [RULE_08] with self-calibration mode, each scan adds a 70 ms self-calibration step
// [RULE_09] scan runs free of host cycle; host samples latest published values
// [RULE_10] converter delivers 16-bit results for channel or cold-junction sensor
// [RULE_11] second mux level selects offset reference or cold-junction sensor
// [RULE_12] raw value is corrected, then filtered, then scaled, using configuration
// [RULE_13] conversion chain, range, terminal block and watchdog errors reach the host
// [RULE_14] host loads configuration; device returns values and module status
// [RULE_15] first-order filter, settings 0..6 give alpha 0 to 0.992
// [RULE_16] filter bypassed in fast scan; filter setting may change any time
// [RULE_17] with monitoring off, fault, overflow and underflow stay 0
// [RULE_18] order: self-cal, cold-junction, wire tests, pairs; then publish together
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH

`define TSS_NCH 16
`define TSS_SLOT_MS 70
`define TSS_WIRE_MS 8
`define TSS_CLK_KHZ 200000
`define TSS_SLOT_CYC (`TSS_SLOT_MS * `TSS_CLK_KHZ)
`define TSS_WIRE_CYC (`TSS_WIRE_MS * `TSS_CLK_KHZ)
`define TSS_WDOG_CYC (`TSS_SLOT_CYC * 32)
`define TSS_RANGE_MV 4'hA
`define TSS_IDX_NONE 5'h10
`define TSS_IDX_ZERO 5'h00
`define TSS_IDX_STEP 5'h01
`define TSS_ALL_CH 16'hFFFF
`define TSS_ALL_PAIR 8'hFF
`define TSS_NO_PAIR 8'h00
`define TSS_GAIN_SHIFT 12
`define TSS_GAIN_ONE 16'h1000
`define TSS_LIM_LO 16'h8000
`define TSS_LIM_HI 16'h7FFF
`define TSS_FSEL_OFF 3'h0
`define TSS_FSEL_MAX 3'h6
`define TSS_SHIFT_BASE 3'h1
`define TSS_SAT_HI 34'sh0_0000_7FFF
`define TSS_SAT_LO 34'sh3_FFFF_8000
`define TSS_TMR_ZERO 32'h0000_0000

`endif

//--- tss_pkg.sv
// types shared by the thermocouple scan sequencer
package tss_pkg;

    typedef enum logic [5:0] {
        TSS_ST_START   = 6'b00_0001,
        TSS_ST_SELFCAL = 6'b00_0010,
        TSS_ST_CJ      = 6'b00_0100,
        TSS_ST_WIRE    = 6'b00_1000,
        TSS_ST_PAIR    = 6'b01_0000,
        TSS_ST_DONE    = 6'b10_0000
    } tss_phase_e;

    typedef enum logic [1:0] {
        TSS_MUX_CHAN = 2'h0,
        TSS_MUX_REF  = 2'h1,
        TSS_MUX_CJ   = 2'h2
    } tss_mux_e;

    typedef struct packed {
        logic fast;
        logic wire_en;
        logic cj_en;
        logic self_calibration_mode;
        logic mon_en;
        logic [15:0] in_use;
        logic [15:0][3:0] range;
        logic [15:0][15:0] align;
        logic [15:0] gain;
        logic [15:0] ofs;
        logic [15:0] lo;
        logic [15:0] hi;
    } tss_cfg_s;

    typedef struct packed {
        logic start;
        tss_mux_e mux;
        logic [2:0] pair;
    } tss_adc_req_s;

    typedef struct packed {
        logic conv_err;
        logic term_missing;
        logic wdog_err;
        logic cfg_err;
    } tss_status_s;

    typedef struct packed {
        tss_phase_e ph;
        logic [31:0] tmr;
        logic [31:0] wdog;
        logic [4:0] idx;
        logic got;
        logic adc_go;
        logic done;
        logic [15:0] da;
        logic [15:0] db;
        tss_cfg_s cfg;
        tss_cfg_s act;
        logic [15:0] off_a;
        logic [15:0] off_b;
        logic [15:0] cj;
        logic [15:0][15:0] filt;
        logic [15:0][15:0] work;
        logic [15:0][15:0] vals;
        logic [15:0] wflt;
        logic [15:0] w_over;
        logic [15:0] w_under;
        logic [15:0] over;
        logic [15:0] under;
        logic [15:0] fault;
        logic conv_w;
        tss_status_s stat;
    } tss_state_s;

endpackage

//--- tss_chan_proc.sv
// per-channel correction, first-order filter and scaling
`timescale 1ns/1ps
`include "tss_regs.svh"
module tss_chan_proc import tss_pkg::*; (
    // raw sample and corrections
    input wire logic [15:0] raw,
    input wire logic [15:0] self_off,
    input wire logic [15:0] align,
    input wire logic [15:0] cj,
    input wire logic cj_add,
    // filter
    input wire logic [15:0] prev,
    input wire logic [2:0] fsel,
    input wire logic bypass,
    // scaling and limits
    input wire logic [15:0] gain,
    input wire logic [15:0] ofs,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi,
    // results
    output logic [15:0] filt,
    output logic [15:0] scaled,
    output logic over,
    output logic under
);
    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v > `TSS_SAT_HI) begin
            return `TSS_LIM_HI;
        end else if (v < `TSS_SAT_LO) begin
            return `TSS_LIM_LO;
        end
        return v[15:0];
    endfunction

    logic signed [33:0] corr_w;
    logic signed [33:0] diff_w;
    logic signed [33:0] prod_w;
    logic [15:0] corr;
    logic [2:0] sel;

    always_comb begin
        // correction by self-calibration offset, alignment and cold junction
        corr_w = 34'(signed'(raw)) - 34'(signed'(self_off)) + 34'(signed'(align))
            + (cj_add ? 34'(signed'(cj)) : '0); // [RULE_12]
        corr = sat16(corr_w);
        // alpha = 1 - 2^-(sel+1) for settings 1 to 6, setting 0 is off; settings above the table clamp to the strongest
        sel = (fsel > `TSS_FSEL_MAX) ? `TSS_FSEL_MAX : fsel;
        diff_w = 34'(signed'(corr)) - 34'(signed'(prev));
        if (bypass || sel == `TSS_FSEL_OFF) begin
            filt = corr; // [RULE_16]
        end else begin
            filt = sat16(34'(signed'(prev)) + (diff_w >>> (sel + `TSS_SHIFT_BASE))); // [RULE_15]
        end
        prod_w = (34'(signed'(filt)) * 34'(signed'(gain))) >>> `TSS_GAIN_SHIFT;
        scaled = sat16(prod_w + 34'(signed'(ofs))); // [RULE_12]
        over = signed'(scaled) > signed'(hi);
        under = signed'(scaled) < signed'(lo);
    end
endmodule

//--- tss_scan_sequencer_assertions.sv
// port-level assertions for the scan sequencer
`timescale 1ns/1ps
module tss_scan_sequencer_assertions import tss_pkg::*; #(
    parameter int unsigned WIRE_CYCLES = 6
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // converter, wire test and terminal monitoring
    input wire tss_adc_req_s ADC_REQ,
    input wire logic WIRE_TEST_ACT,
    input wire logic [3:0] WIRE_TEST_CHAN,
    input wire logic TERM_PRESENT,
    // host side
    input wire logic [15:0][15:0] VALUES,
    input wire logic [15:0] CH_OVER,
    input wire logic [15:0] CH_UNDER,
    input wire logic [15:0] CH_FAULT,
    input wire tss_status_s MOD_STATUS,
    input wire logic CYCLE_DONE
);
    logic [31:0] wcnt_ff;
    logic [3:0] chan_ff;
    logic act_ff;
    // counts cycles of one wire step; a channel change restarts it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            act_ff <= 1'b0;
            chan_ff <= 4'h0;
            wcnt_ff <= 32'h0000_0000;
        end else begin
            act_ff <= WIRE_TEST_ACT;
            chan_ff <= WIRE_TEST_CHAN;
            wcnt_ff <= (WIRE_TEST_ACT && act_ff && WIRE_TEST_CHAN == chan_ff) ? wcnt_ff + 1 : 32'h0000_0000;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence slot_hold_s;
        (!ADC_REQ.start && $stable(ADC_REQ.mux) && $stable(ADC_REQ.pair)) [*8];
    endsequence
    sequence outputs_still_s;
        $stable(VALUES) && $stable(CH_OVER) && $stable(CH_UNDER) && $stable(CH_FAULT);
    endsequence
    step_end_s_a: assert property (act_ff && (!WIRE_TEST_ACT || WIRE_TEST_CHAN != chan_ff)
        |-> wcnt_ff == WIRE_CYCLES - 1)
        else $error("wire step length wrong");
    wire_bound_a: assert property (WIRE_TEST_ACT |-> wcnt_ff < WIRE_CYCLES)
        else $error("wire step too long");
    done_pulse_a: assert property (CYCLE_DONE |=> !CYCLE_DONE)
        else $error("cycle done held too long");
    slot_hold_a: assert property (ADC_REQ.start |=> slot_hold_s)
        else $error("slot request not held");
    values_hold_a: assert property (!CYCLE_DONE |-> outputs_still_s)
        else $error("outputs changed outside cycle done");
    wire_quiet_a: assert property (WIRE_TEST_ACT |-> !ADC_REQ.start)
        else $error("conversion during wire step");
    done_quiet_a: assert property (CYCLE_DONE |-> !ADC_REQ.start && !WIRE_TEST_ACT)
        else $error("activity in done cycle");
    term_flag_a: assert property (1'b1 |=> MOD_STATUS.term_missing == !$past(TERM_PRESENT))
        else $error("terminal flag wrong");
endmodule

//--- tss_adc_model.sv
// converter model answering the sequencer's slot requests
`timescale 1ns/1ps
module tss_adc_model import tss_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request and controls
    input wire tss_adc_req_s req,
    input wire logic [15:0] base,
    input wire logic slow,
    input wire logic drop,
    // answer
    output logic done,
    output logic [15:0] da,
    output logic [15:0] db
);
    int cnt;
    logic [15:0] junk;
    // outside the answer cycle the data lines wander, so stale data is never trusted
    assign da = done ? base + {13'h0000, req.pair} : junk;
    assign db = done ? base + 16'h0100 + {13'h0000, req.pair} : ~junk;
    always @(posedge clk) begin
        junk <= rst ? 16'h5A5A : junk + 16'h1357;
        done <= 1'b0;
        if (rst) begin
            cnt <= 0;
        end else if (req.start) begin
            cnt <= slow ? 15 : 2;
        end else if (cnt == 1) begin
            done <= !drop;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

//--- tss_scan_sequencer_test.sv
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
module tss_scan_sequencer_test import tss_pkg::*; ;
    localparam int SLOT = 20;
    localparam int WIRE = 6;
    // fast, wire, cold junction, self-cal, in-use mask
    localparam logic [19:0] TAB [6] = '{20'h0_FFFF, 20'h0_0103, 20'hF_0103, 20'h9_0001, 20'h8_0000, 20'h4_0001};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_load = 1'b0;
    logic [2:0] filter_sel = 3'h0;
    tss_cfg_s cfg_in;
    tss_adc_req_s adc_req;
    tss_status_s mod_status;
    logic adc_done, wire_act, wire_bad, wire_open, term_present, cycle_done, slow, drop;
    logic [15:0] adc_a, adc_b, base, ch_over, ch_under, ch_fault;
    logic [3:0] wire_chan;
    logic [15:0][15:0] values;
    int fail_count = 0;
    int num_checks = 0;
    assign wire_open = wire_bad && wire_chan == 4'h1;
    always #2.5 clk = ~clk;
    tss_scan_sequencer #(.SLOT_CYCLES(SLOT), .WIRE_CYCLES(WIRE), .WDOG_CYCLES(200)) dut_u (.CLK(clk),
        .SYS_RST(sys_rst), .CFG_LOAD(cfg_load), .CFG_IN(cfg_in), .FILTER_SEL(filter_sel), .ADC_REQ(adc_req),
        .ADC_DONE(adc_done), .ADC_DATA_A(adc_a), .ADC_DATA_B(adc_b), .WIRE_TEST_ACT(wire_act),
        .WIRE_TEST_CHAN(wire_chan), .WIRE_OPEN(wire_open), .TERM_PRESENT(term_present), .VALUES(values),
        .CH_OVER(ch_over), .CH_UNDER(ch_under), .CH_FAULT(ch_fault), .MOD_STATUS(mod_status),
        .CYCLE_DONE(cycle_done));
    tss_adc_model adc_u (.clk(clk), .rst(sys_rst), .req(adc_req), .base(base), .slow(slow), .drop(drop),
        .done(adc_done), .da(adc_a), .db(adc_b));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cycle_done !== 1'b1 && n < 4000);
        if (n >= 4000) check("cycle done", 0, 1);
    endtask
    // a load lands at the next scan start, so two scans pass before results are fresh
    task automatic load(input tss_cfg_s c);
        int n;
        @(negedge clk);
        cfg_in = c;
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
        wait_done(n);
        wait_done(n);
    endtask
    task automatic next_start(output tss_mux_e m, output logic saw_wire);
        saw_wire = 1'b0;
        do begin
            @(negedge clk);
            saw_wire |= wire_act;
        end while (adc_req.start !== 1'b1);
        m = adc_req.mux;
    endtask
    function automatic tss_cfg_s base_cfg(input logic [15:0] use_mask);
        tss_cfg_s c;
        c = '0;
        c.in_use = use_mask;
        for (int i = 0; i < 16; i++) c.range[i] = 4'hA;
        c.gain = 16'h1000;
        c.lo = 16'h8000;
        c.hi = 16'h7FFF;
        return c;
    endfunction
    task automatic t_values();
        tss_cfg_s c;
        c = base_cfg(16'hFFFF);
        c.hi = 16'h0150;
        load(c);
        for (int k = 0; k < 8; k++) begin
            check("value a", values[k], 16'h0100 + k);
            check("value b", values[k + 8], 16'h0200 + k);
        end
        check("flags off", ch_over | ch_under | ch_fault, 0);
        c.mon_en = 1'b1;
        c.lo = 16'h0150;
        load(c);
        check("over", ch_over, 16'hFF00);
        check("fault", ch_fault, 16'hFFFF);
        check("under", ch_under, 16'h00FF);
        $display("test values done");
    endtask
    task automatic t_filter();
        int n;
        tss_cfg_s c;
        c = base_cfg(16'hFFFF);
        wait_done(n);
        base = 16'h0140;
        filter_sel = 3'h1;
        wait_done(n);
        check("filter a", values[0], 16'h0110);
        check("filter b", values[15], 16'h0217);
        filter_sel = 3'h6;
        c.fast = 1'b1;
        load(c);
        check("bypass", values[0], 16'h0140);
        filter_sel = 3'h0;
        $display("test filter done");
    endtask
    task automatic t_faults();
        int n;
        tss_cfg_s c;
        c = base_cfg(16'h0003);
        c.wire_en = 1'b1;
        c.mon_en = 1'b1;
        c.range[3] = 4'hB;
        wire_bad = 1'b1;
        load(c);
        check("wire fault", ch_fault, 16'h0002);
        check("range code", mod_status.cfg_err, 1);
        wire_bad = 1'b0;
        slow = 1'b1;
        drop = 1'b1;
        base = 16'h0180;
        wait_done(n);
        wait_done(n);
        check("conv err", mod_status.conv_err, 1);
        check("conv fault", ch_fault, 16'h0003);
        drop = 1'b0;
        wait_done(n);
        wait_done(n);
        check("conv ok", mod_status.conv_err, 0);
        check("slow value", values[1], 16'h0181);
        // wired normal scans outlast the shortened watchdog
        check("watchdog", mod_status.wdog_err, 1);
        term_present = 1'b0;
        repeat (2) @(negedge clk);
        check("terminal", mod_status.term_missing, 1);
        check("watchdog clear", mod_status.wdog_err, 0);
        check("range held", mod_status.cfg_err, 1);
        term_present = 1'b1;
        slow = 1'b0;
        $display("test faults done");
    endtask
    task automatic t_timing();
        int n, pairs, exp;
        tss_cfg_s c;
        tss_mux_e m;
        logic w;
        for (int r = 0; r < 6; r++) begin
            c = base_cfg(TAB[r][15:0]);
            {c.fast, c.wire_en, c.cj_en, c.self_calibration_mode} = TAB[r][19:16];
            pairs = 0;
            for (int k = 0; k < 8; k++) pairs += (!c.fast || c.in_use[k] || c.in_use[k + 8]);
            exp = 2 + SLOT * (pairs + c.cj_en + c.self_calibration_mode);
            exp += WIRE * c.wire_en * (c.fast ? $countones(c.in_use) : 16);
            load(c);
            wait_done(n);
            check("scan period", n, exp);
            if (r == 2) begin
                next_start(m, w);
                check("first mux", m, TSS_MUX_REF);
                next_start(m, w);
                check("second mux", m, TSS_MUX_CJ);
                next_start(m, w);
                check("pair mux", m, TSS_MUX_CHAN);
                check("wire first", w, 1);
            end
        end
        $display("test timing done");
    endtask
    initial begin
        cfg_in = base_cfg(16'h0000);
        base = 16'h0100;
        slow = 1'b0;
        drop = 1'b0;
        wire_bad = 1'b0;
        term_present = 1'b1;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        t_values();
        t_filter();
        t_faults();
        t_timing(); // self-cal offsets stay behind, so value tests run first
        stop_test();
    end
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
endmodule
bind tss_scan_sequencer tss_scan_sequencer_assertions #(.WIRE_CYCLES(WIRE_CYCLES)) chk_u (.CLK(CLK),
    .SYS_RST(SYS_RST), .ADC_REQ(ADC_REQ), .WIRE_TEST_ACT(WIRE_TEST_ACT), .WIRE_TEST_CHAN(WIRE_TEST_CHAN),
    .TERM_PRESENT(TERM_PRESENT), .VALUES(VALUES), .CH_OVER(CH_OVER), .CH_UNDER(CH_UNDER), .CH_FAULT(CH_FAULT),
    .MOD_STATUS(MOD_STATUS), .CYCLE_DONE(CYCLE_DONE));
